// ===== ccap_pkg.sv
// Shared types and constants for the cascade byte capture chain.
// Assumes one byte clock drives every receiver of the chain.
package ccap_pkg;

    // ----------------------------------------------------------------
    // Widths and reset values
    // ----------------------------------------------------------------
    localparam int DATA_W = 8;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int T46_NS        = 20;
    // Longest time: round down, never below one cycle
    localparam int FALL_CYC_DEF  = (T46_NS / CLK_PERIOD_NS < 1) ?
                                   1 : T46_NS / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic              half_valid;
        logic              half_sync;
        logic              byte_valid;
        logic              is_sync;
        logic              is_cmd;
        logic              violation;
        logic [DATA_W-1:0] data;
    } ccap_sym_t;

    typedef struct packed {
        logic              is_cmd;
        logic              violation;
        logic [DATA_W-1:0] data;
    } ccap_byte_t;

    localparam ccap_byte_t BYTE_RST = '0;

    typedef enum logic [1:0] {
        REL_IDLE = 2'b00,
        REL_DEC  = 2'b01,
        REL_OUT  = 2'b11
    } ccap_rel_t;

endpackage

// ===== ccap_hold_reg.sv
// One byte latch stage with a load enable.
// Assumes load is synchronous to the byte clock.
`timescale 1ns/10ps
module ccap_hold_reg import ccap_pkg::*; #(
    parameter int W = $bits(ccap_byte_t)
) (
    input  wire logic         clk_sys_in,  // Byte clock
    input  wire logic         arst_n_in,   // Async reset, low
    input  wire logic         load_in,     // Take d this edge
    input  wire logic [W-1:0] d_in,        // Next contents
    output logic      [W-1:0] q_out        // Held contents
);

    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    if (W < 1) begin : g_bad_w
        $error("ccap_hold_reg: W must be at least 1");
    end

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            q_out <= '0;
        end else if (load_in) begin
            q_out <= d_in;
        end
    end

endmodule

// ===== ccap_fall_delay.sv
// Fixed delay from a low catch enable to the forced drop of got-mine.
// Assumes the low level input is synchronous to the byte clock.
`timescale 1ns/10ps
module ccap_fall_delay #(
    parameter int DEPTH = 2
) (
    input  wire logic clk_sys_in,  // Byte clock
    input  wire logic arst_n_in,   // Async reset, low
    input  wire logic low_in,      // Catch enable is low
    output logic      low_out      // Same, DEPTH cycles later
);

    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    if (DEPTH < 1) begin : g_bad_depth
        $error("ccap_fall_delay: DEPTH must be at least 1");
    end

    logic [DEPTH-1:0] stage_r;

    // ----------------------------------------------------------------
    // Shift stages
    // ----------------------------------------------------------------
    for (genvar i = 0; i < DEPTH; i++) begin : g_stage
        always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
                stage_r[i] <= 1'b0;
            end else if (i == 0) begin
                stage_r[i] <= low_in;
            end else begin
                stage_r[i] <= stage_r[(i == 0) ? 0 : i-1];
            end
        end
    end

    assign low_out = stage_r[DEPTH-1];

endmodule

// ===== ccap_receiver.sv
// Byte slot capture control for one receiver of a cascaded chain.
// Assumes the serial decoder delivers half-byte and whole-byte events,
// synchronous to the byte clock, on sym_in.
`timescale 1ns/10ps

module ccap_receiver import ccap_pkg::*; #(
    parameter int FALL_CYC = FALL_CYC_DEF
) (
    input  wire logic              clk_sys_in,         // Byte clock
    input  wire logic              arst_n_in,          // Async reset, low
    input  wire ccap_sym_t         sym_in,             // Decoded events
    input  wire logic              catch_enable_in,    // From upstream
    output logic                   got_mine_out,       // To downstream
    output logic      [DATA_W-1:0] data_out,           // Released byte
    output logic                   code_violation_out, // Released flag
    output logic                   data_out_strobe,    // Data released
    output logic                   command_out_strobe  // Command released
);

    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    if (FALL_CYC < 1) begin : g_bad_fall
        $error("ccap_receiver: FALL_CYC must be at least 1");
    end

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic       ce_r;
    logic       claim_r;
    logic       full_r;
    logic       gm_r;
    logic       gm_nxt;
    logic       fall_low;
    logic       sync_seen;
    logic       half_data;
    logic       ce_fall;
    logic       take_byte;
    logic       rel_go;
    ccap_rel_t  rel_r;
    ccap_rel_t  rel_nxt;
    ccap_byte_t in_d;
    ccap_byte_t in_q;
    ccap_byte_t dec_q;
    ccap_byte_t out_q;

    // ----------------------------------------------------------------
    // Event decode
    // ----------------------------------------------------------------
    assign sync_seen = sym_in.byte_valid && sym_in.is_sync;
    assign half_data = sym_in.half_valid && !sym_in.half_sync;
    // Previous sample against current one gives the edge
    assign ce_fall   = ce_r && !catch_enable_in;
    // Violation does not stop the claim: flagged bytes count too
    assign take_byte = claim_r && sym_in.byte_valid
                       && !sym_in.is_sync;
    // Release only when there is a byte to give out
    assign rel_go    = full_r && (sync_seen || ce_fall);

    // ----------------------------------------------------------------
    // Catch enable sample
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ce_r <= 1'b0;
        end else begin
            ce_r <= catch_enable_in;
        end
    end

    // ----------------------------------------------------------------
    // Claim of the byte now on the line
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            claim_r <= 1'b0;
        end else if (!catch_enable_in || sync_seen) begin
            claim_r <= 1'b0;
        end else if (take_byte) begin
            claim_r <= 1'b0;
        end else if (half_data && !full_r && !claim_r) begin
            claim_r <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Full flag: one byte per arming
    // ----------------------------------------------------------------
    // Cleared by Sync or by a low enable, so low then high re-arms
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            full_r <= 1'b0;
        end else if (sync_seen || !catch_enable_in) begin
            full_r <= 1'b0;
        end else if (take_byte) begin
            full_r <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Got-mine
    // ----------------------------------------------------------------
    ccap_fall_delay #(
        .DEPTH      (FALL_CYC)
    ) u_fall (
        .clk_sys_in (clk_sys_in),
        .arst_n_in  (arst_n_in),
        .low_in     (!catch_enable_in),
        .low_out    (fall_low)
    );

    // A delayed fall still in the pipe after a re-arm must not undo
    // the claim made since, or got-mine and the held slot disagree
    always_comb begin
        gm_nxt = gm_r;
        if (sync_seen) begin
            gm_nxt = 1'b0;
        end else if (half_data && catch_enable_in
                     && !full_r && !claim_r) begin
            gm_nxt = 1'b1;
        end else if (fall_low && !claim_r && !full_r) begin
            gm_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            gm_r <= 1'b0;
        end else begin
            gm_r <= gm_nxt;
        end
    end

    assign got_mine_out = gm_r;

    // ----------------------------------------------------------------
    // Latch chain: input, decoder, output
    // ----------------------------------------------------------------
    always_comb begin
        in_d           = BYTE_RST;
        in_d.is_cmd    = sym_in.is_cmd;
        in_d.violation = sym_in.violation;
        in_d.data      = sym_in.data;
    end

    ccap_hold_reg u_in_latch (
        .clk_sys_in (clk_sys_in),
        .arst_n_in  (arst_n_in),
        .load_in    (take_byte),
        .d_in       (in_d),
        .q_out      (in_q)
    );

    ccap_hold_reg u_dec_latch (
        .clk_sys_in (clk_sys_in),
        .arst_n_in  (arst_n_in),
        .load_in    (rel_go),
        .d_in       (in_q),
        .q_out      (dec_q)
    );

    ccap_hold_reg u_out_latch (
        .clk_sys_in (clk_sys_in),
        .arst_n_in  (arst_n_in),
        .load_in    (rel_r == REL_DEC),
        .d_in       (dec_q),
        .q_out      (out_q)
    );

    // ----------------------------------------------------------------
    // Release sequencer
    // ----------------------------------------------------------------
    // Fixed two-cycle path keeps every receiver of a chain in step
    always_comb begin
        rel_nxt = REL_IDLE;
        unique case (rel_r)
            REL_IDLE: begin
                rel_nxt = rel_go ? REL_DEC : REL_IDLE;
            end
            REL_DEC: begin
                rel_nxt = REL_OUT;
            end
            REL_OUT: begin
                rel_nxt = rel_go ? REL_DEC : REL_IDLE;
            end
            default: begin
                rel_nxt = REL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rel_r <= REL_IDLE;
        end else begin
            rel_r <= rel_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign data_out           = out_q.data;
    assign code_violation_out = out_q.violation;
    // Strobe decoded from state flops: one cycle, same on every receiver
    assign data_out_strobe    = (rel_r == REL_OUT)
                                && !out_q.is_cmd;
    assign command_out_strobe = (rel_r == REL_OUT)
                                && out_q.is_cmd;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!arst_n_in);

    property p_strobe_one;
        (data_out_strobe || command_out_strobe)
            |=> !(data_out_strobe || command_out_strobe);
    endproperty
    a_strobe_one: assert property (p_strobe_one)
        else $error("strobe held longer than one cycle");

    property p_dec_load;
        rel_go |=> (dec_q == $past(in_q))
                   && (!$past(sync_seen) || !got_mine_out);
    endproperty
    a_dec_load: assert property (p_dec_load)
        else $error("decoder latch or got-mine wrong after release");

    property p_two_cycles;
        rel_go |-> ##2 ((data_out_strobe || command_out_strobe)
                        && data_out == $past(in_q.data, 2));
    endproperty
    a_two_cycles: assert property (p_two_cycles)
        else $error("release not two cycles after trigger");

    property p_hold;
        full_r && catch_enable_in && !sync_seen |=> $stable(in_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("held byte overwritten");

    property p_no_catch_low;
        !catch_enable_in |=> !claim_r && !full_r;
    endproperty
    a_no_catch_low: assert property (p_no_catch_low)
        else $error("capture while catch enable low");

    property p_rise_cause;
        $rose(got_mine_out) |-> $past(half_data && catch_enable_in);
    endproperty
    a_rise_cause: assert property (p_rise_cause)
        else $error("got-mine rose without non-Sync half byte");

    property p_sync_drop;
        sync_seen |=> !got_mine_out;
    endproperty
    a_sync_drop: assert property (p_sync_drop)
        else $error("got-mine high after Sync");

    property p_fall_delay;
        (ce_r && !catch_enable_in) ##1 !catch_enable_in
            ##1 !catch_enable_in |=> !got_mine_out;
    endproperty
    a_fall_delay: assert property (p_fall_delay)
        else $error("got-mine not low after enable fall delay");

    property p_viol_counts;
        take_byte && sym_in.violation |=> full_r && in_q.violation;
    endproperty
    a_viol_counts: assert property (p_viol_counts)
        else $error("violating byte not taken");

    property p_rearm_rise;
        fall_low && half_data && catch_enable_in && !full_r && !claim_r
            |=> got_mine_out;
    endproperty
    a_rearm_rise: assert property (p_rearm_rise)
        else $error("got-mine lost to a stale enable fall");

    c_release: cover property (rel_go ##2 data_out_strobe);
    c_cmd:     cover property (command_out_strobe);
    c_rearm:   cover property (ce_fall ##[1:8] $rose(got_mine_out));
    c_viol:    cover property (data_out_strobe && code_violation_out);

endmodule

// ===== ccap_link_model.sv
// Link side model: serial decoder events as a sender produces them.
// Assumes the testbench calls its tasks in order, one symbol at a time.
`timescale 1ns/10ps
module ccap_link_model import ccap_pkg::*; (
    input  wire logic clk_sys_in, // Byte clock
    output ccap_sym_t sym_out     // Decoded events to receiver
);
    logic [DATA_W-1:0] last_r;

    initial begin
        sym_out = '0;
        last_r  = '0;
    end

    // ----------------------------------------------------------------
    // Symbol phases, each 1 ns after a rising edge
    // ----------------------------------------------------------------
    task automatic send_half(input logic sync);
        @(posedge clk_sys_in);
        #1;
        sym_out            = '0;
        sym_out.data       = ~last_r;
        sym_out.half_valid = 1'b1;
        sym_out.half_sync  = sync;
    endtask

    task automatic send_whole(input logic sync, input logic cmd,
                              input logic viol, input logic [7:0] d);
        @(posedge clk_sys_in);
        #1;
        sym_out            = '0;
        sym_out.byte_valid = 1'b1;
        sym_out.is_sync    = sync;
        sym_out.is_cmd     = cmd;
        sym_out.violation  = viol;
        sym_out.data       = d;
        last_r             = d;
    endtask

    // Data lines toggle when idle so a stale byte is never mistaken
    task automatic go_idle();
        @(posedge clk_sys_in);
        #1;
        sym_out      = '0;
        sym_out.data = ~last_r;
    endtask
endmodule

// ===== tb_ccap_receiver.sv
// Self-checking bench for one receiver of the capture chain.
// Assumes the link model drives sym_in; bench drives catch enable.
`timescale 1ns/10ps
module tb_ccap_receiver import ccap_pkg::*;;
    localparam int FC      = 2;
    localparam int WDOG_NS = 2000 * CLK_PERIOD_NS;

    logic              clk_sys_in;
    logic              arst_n_in;
    logic              catch_enable_in;
    ccap_sym_t         sym;
    logic              got_mine_out;
    logic [DATA_W-1:0] data_out;
    logic              code_violation_out;
    logic              data_out_strobe;
    logic              command_out_strobe;
    int                failures;
    int                cmp_count;

    ccap_link_model ccap_link_model_i (
        .clk_sys_in (clk_sys_in),
        .sym_out    (sym)
    );

    ccap_receiver #(.FALL_CYC(FC)) ccap_receiver_i (
        .clk_sys_in         (clk_sys_in),
        .arst_n_in          (arst_n_in),
        .sym_in             (sym),
        .catch_enable_in    (catch_enable_in),
        .got_mine_out       (got_mine_out),
        .data_out           (data_out),
        .code_violation_out (code_violation_out),
        .data_out_strobe    (data_out_strobe),
        .command_out_strobe (command_out_strobe)
    );

    initial begin
        clk_sys_in = 1'b0;
        forever #(CLK_PERIOD_NS / 2) clk_sys_in = ~clk_sys_in;
    end

    // ----------------------------------------------------------------
    // Shared helpers
    // ----------------------------------------------------------------
    task automatic tick();
        @(posedge clk_sys_in);
        #1;
    endtask

    task automatic chk_out(input logic [2:0] exp);
        logic [2:0] got;
        got = {got_mine_out, data_out_strobe, command_out_strobe};
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t ctl exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic chk_data(input logic [8:0] exp);
        logic [8:0] got;
        got = {code_violation_out, data_out};
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t data exp=%h got=%h", $time, exp, got);
        end
    endtask

    // Half sampled, got-mine checked, then whole byte sampled
    task automatic put_byte(input logic sync, input logic cmd,
                            input logic viol, input logic [7:0] d,
                            input logic gm);
        ccap_link_model_i.send_half(sync);
        ccap_link_model_i.send_whole(sync, cmd, viol, d);
        chk_out({gm, 2'b00});
        ccap_link_model_i.go_idle();
    endtask

    // Called in the cycle after a Sync byte was sampled
    task automatic release_chk(input logic [1:0] st, input logic [8:0] d);
        chk_out(3'b000);
        tick();
        chk_out({1'b0, st});
        chk_data(d);
        tick();
        chk_out(3'b000);
    endtask

    task automatic finish_test();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_sync_release();
        catch_enable_in = 1'b1;
        put_byte(1'b0, 1'b0, 1'b0, 8'ha5, 1'b1);
        put_byte(1'b1, 1'b0, 1'b0, 8'h00, 1'b1);
        release_chk(2'b10, 9'h0a5);
        $display("test_sync_release done");
    endtask

    task automatic test_hold_first();
        put_byte(1'b0, 1'b0, 1'b0, 8'h3c, 1'b1);
        put_byte(1'b0, 1'b0, 1'b0, 8'hc3, 1'b1);
        put_byte(1'b1, 1'b0, 1'b0, 8'h00, 1'b1);
        release_chk(2'b10, 9'h03c);
        put_byte(1'b1, 1'b0, 1'b0, 8'h00, 1'b0);
        release_chk(2'b00, 9'h03c);
        $display("test_hold_first done");
    endtask

    task automatic test_enable_low();
        catch_enable_in = 1'b0;
        put_byte(1'b0, 1'b0, 1'b0, 8'h77, 1'b0);
        catch_enable_in = 1'b1;
        put_byte(1'b1, 1'b0, 1'b0, 8'h00, 1'b0);
        release_chk(2'b00, 9'h03c);
        $display("test_enable_low done");
    endtask

    task automatic test_violation_cmd();
        put_byte(1'b0, 1'b1, 1'b1, 8'h5a, 1'b1);
        put_byte(1'b1, 1'b0, 1'b0, 8'h00, 1'b1);
        release_chk(2'b01, 9'h15a);
        $display("test_violation_cmd done");
    endtask

    // Enable fall releases in two cycles; got-mine waits FC+1 samples
    task automatic test_enable_fall();
        put_byte(1'b0, 1'b0, 1'b0, 8'h96, 1'b1);
        catch_enable_in = 1'b0;
        for (int i = 0; i < FC; i++) begin
            tick();
            chk_out({1'b1, (i == 1), 1'b0});
        end
        chk_data(9'h096);
        tick();
        chk_out(3'b000);
        catch_enable_in = 1'b1;
        put_byte(1'b0, 1'b0, 1'b0, 8'h69, 1'b1);
        put_byte(1'b1, 1'b0, 1'b0, 8'h00, 1'b1);
        release_chk(2'b10, 9'h069);
        $display("test_enable_fall done");
    endtask

    // Bench plays the primary of a two-receiver auto-repeat chain:
    // its got-mine is our enable, and it re-arms off our got-mine
    task automatic test_auto_repeat();
        for (int w = 0; w < 2; w++) begin
            catch_enable_in = 1'b1;
            put_byte(1'b0, 1'b0, 1'b0, 8'h21 + 8'(w), 1'b1);
            catch_enable_in = ~got_mine_out;
            tick();
            chk_out(3'b100);
            tick();
            chk_out(3'b110);
            chk_data({1'b0, 8'h21 + 8'(w)});
            tick();
            chk_out(3'b000);
        end
        $display("test_auto_repeat done");
    endtask

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        failures        = 0;
        cmp_count       = 0;
        arst_n_in       = 1'b0;
        catch_enable_in = 1'b0;
        repeat (6) @(posedge clk_sys_in);
        #1;
        arst_n_in = 1'b1;
        tick();
        chk_out(3'b000);
        chk_data(9'h000);
        test_sync_release();
        test_hold_first();
        test_enable_low();
        test_violation_cmd();
        test_enable_fall();
        test_auto_repeat();
        finish_test();
    end

    // Tests need about 75 cycles; a hang runs far past that
    initial begin
        #(WDOG_NS);
        failures++;
        finish_test();
    end
endmodule
